// [hdl/mds_drum.v]
/*
  Masked event drum sequencer: sixteen steps of sixteen outputs, timer and
  event stepping, jog, preset and a masked discrete or word output.
  Assumes scanPulse comes from logic on clk and the control pins come from
  outside the clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mds_defines.vh"

module mds_drum #(
  parameter integer UNIT_CYCLES = `MDS_UNIT_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Scan timing from the controller
  input  wire        scanPulse,
  // Control pins
  input  wire        runMode,
  input  wire        startIn,
  input  wire        resetIn,
  input  wire        jogIn,
  input  wire [15:0] eventIn,
  // Register port
  input  wire [6:0]  regAddr,
  input  wire [15:0] regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [15:0] regRdData,
  // Drum outputs
  output reg  [15:0] discreteOut,
  output reg  [15:0] wordOut,
  output wire        sequenceCompleteFlag
);

  localparam integer PIN_W = 20;

  // Bit positions of the control pins inside the synchroniser word
  localparam integer PIN_RUN   = 19;
  localparam integer PIN_START = 18;
  localparam integer PIN_RESET = 17;
  localparam integer PIN_JOG   = 16;

  function [3:0] stepIndex;
    input [4:0] step;
    begin
      stepIndex = step[3:0] - 4'h1;
    end
  endfunction

  function inRange;
    input [6:0] addr;
    input [6:0] base;
    input [6:0] size;
    begin
      inRange = (addr >= base) && (addr < base + size);
    end
  endfunction

  // Pin synchronisers
  reg  [PIN_W-1:0] pinS1_r;
  reg  [PIN_W-1:0] pinS2_r;
  reg  [PIN_W-1:0] pinS3_r;
  reg  [PIN_W-1:0] pinF_r;
  wire [PIN_W-1:0] pinRaw;

  assign pinRaw = {runMode, startIn, resetIn, jogIn, eventIn};

  always @(posedge clk) begin
    if (!rst_n) begin
      pinS1_r <= {PIN_W{1'b0}};
      pinS2_r <= {PIN_W{1'b0}};
      pinS3_r <= {PIN_W{1'b0}};
      pinF_r  <= {PIN_W{1'b0}};
    end else begin
      pinS1_r <= pinRaw;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
      // A level is accepted once two later stages agree
      pinF_r  <= (pinS2_r & pinS3_r) | (pinF_r & (pinS2_r | pinS3_r));
    end
  end

  wire        runF    = pinF_r[PIN_RUN];
  wire        startF  = pinF_r[PIN_START];
  wire        resetF  = pinF_r[PIN_RESET];
  wire        jogF    = pinF_r[PIN_JOG];
  wire [15:0] eventF  = pinF_r[15:0];

  reg runPrev_r;
  reg jogPrev_r;

  // Configuration storage
  reg [15:0] pattern_r  [0:`MDS_STEPS-1];
  reg [15:0] cps_r      [0:`MDS_STEPS-1];
  reg [15:0] maskMem_r  [0:`MDS_MASK_WORDS-1];
  reg [15:0] timebase_r;
  reg [15:0] eventEn_r;
  reg [4:0]  maskBase_r;
  reg        wordMode_r;

  // Status counters
  reg [15:0] countsInStep_r;
  reg [15:0] timerValue_r;
  reg [4:0]  presetStep_r;
  reg [4:0]  currentStep_r;
  reg        complete_r;
  reg [19:0] prescale_r;

  assign sequenceCompleteFlag = complete_r;

  wire [3:0]  curIdx    = stepIndex(currentStep_r);
  wire [4:0]  maskIdx   = maskBase_r + {1'b0, curIdx};
  wire [15:0] maskedOut = pattern_r[curIdx] & maskMem_r[maskIdx];
  wire [15:0] curCps    = cps_r[curIdx];

  // A step without an assigned event is timed unconditionally
  wire eventOk   = ~eventEn_r[curIdx] | eventF[curIdx];
  wire runEntry  = runF & ~runPrev_r;
  wire seqReset  = resetF | runEntry;
  wire jogEdge   = jogF & ~jogPrev_r;
  wire timerRun  = startF & eventOk & ~complete_r & ~seqReset;
  wire unitTick  = (prescale_r == UNIT_CYCLES - 1);
  wire countDone = timerRun & unitTick & (timerValue_r + 16'h0001 >= timebase_r);
  wire stepDue   = scanPulse & timerRun & (countsInStep_r == curCps);

  wire wrPreset  = regWr & (regAddr == `MDS_REG_PRESET);
  wire wrCurrent = regWr & (regAddr == `MDS_REG_CURRENT);

  // Step sixteen completes the drum instead of wrapping to step one
  wire atLastStep = (currentStep_r >= `MDS_LAST_STEP);

  // Unit prescaler runs freely so the first count is not stretched
  always @(posedge clk) begin
    if (!rst_n) begin
      prescale_r <= 20'h00000;
    end else if (unitTick) begin
      prescale_r <= 20'h00000;
    end else begin
      prescale_r <= prescale_r + 20'h00001;
    end
  end

  // Sequencing
  always @(posedge clk) begin
    if (!rst_n) begin
      runPrev_r      <= 1'b0;
      jogPrev_r      <= 1'b0;
      countsInStep_r <= 16'h0000;
      timerValue_r   <= 16'h0000;
      presetStep_r   <= `MDS_PRESET_RST;
      currentStep_r  <= `MDS_PRESET_RST;
      complete_r     <= 1'b0;
    end else begin
      runPrev_r <= runF;
      jogPrev_r <= jogF;
      if (wrPreset) begin
        presetStep_r <= regWrData[4:0];
      end
      if (seqReset) begin
        currentStep_r  <= wrPreset ? regWrData[4:0] : presetStep_r;
        countsInStep_r <= 16'h0000;
        timerValue_r   <= 16'h0000;
        complete_r     <= 1'b0;
      end else if (wrCurrent) begin
        currentStep_r  <= regWrData[4:0];
        countsInStep_r <= 16'h0000;
        timerValue_r   <= 16'h0000;
        complete_r     <= 1'b0;
      end else if (complete_r) begin
        // Hold step and outputs; a preset write releases the hold
        if (wrPreset) begin
          complete_r <= 1'b0;
        end
      end else if (jogEdge || stepDue) begin
        countsInStep_r <= 16'h0000;
        timerValue_r   <= 16'h0000;
        if (atLastStep) begin
          complete_r <= 1'b1;
        end else begin
          currentStep_r <= currentStep_r + 5'h01;
        end
      end else if (timerRun && unitTick) begin
        if (countDone) begin
          timerValue_r <= 16'h0000;
          if (countsInStep_r != curCps) begin
            countsInStep_r <= countsInStep_r + 16'h0001;
          end
        end else begin
          timerValue_r <= timerValue_r + 16'h0001;
        end
      end
    end
  end

  // Write decodes; read-only and unmapped indices are ignored
  wire wrPattern  = regWr & inRange(regAddr, `MDS_PATTERN_BASE, 7'h10);
  wire wrCps      = regWr & inRange(regAddr, `MDS_CPS_BASE, 7'h10);
  wire wrMask     = regWr & inRange(regAddr, `MDS_MASK_MEM_BASE, 7'h20);
  wire wrTimebase = regWr & (regAddr == `MDS_REG_TIMEBASE);
  wire wrEventEn  = regWr & (regAddr == `MDS_REG_EVENT_EN);
  wire wrMaskBase = regWr & (regAddr == `MDS_REG_MASK_BASE);
  wire wrControl  = regWr & (regAddr == `MDS_REG_CONTROL);

  // Pattern table; blank entries after reset
  integer i;
  always @(posedge clk) begin
    if (!rst_n) begin
      for (i = 0; i < `MDS_STEPS; i = i + 1) begin
        pattern_r[i] <= 16'h0000;
      end
    end else if (wrPattern) begin
      pattern_r[regAddr[3:0]] <= regWrData;
    end
  end

  // Counts per step; zero lets a step leave on the next scan
  integer j;
  always @(posedge clk) begin
    if (!rst_n) begin
      for (j = 0; j < `MDS_STEPS; j = j + 1) begin
        cps_r[j] <= 16'h0000;
      end
    end else if (wrCps) begin
      cps_r[regAddr[3:0]] <= regWrData;
    end
  end

  // Mask words; rewriting one takes effect on the next clock
  integer m;
  always @(posedge clk) begin
    if (!rst_n) begin
      for (m = 0; m < `MDS_MASK_WORDS; m = m + 1) begin
        maskMem_r[m] <= 16'h0000;
      end
    end else if (wrMask) begin
      maskMem_r[regAddr[4:0]] <= regWrData;
    end
  end

  // Scalar settings
  always @(posedge clk) begin
    if (!rst_n) begin
      timebase_r <= `MDS_TIMEBASE_RST;
      eventEn_r  <= 16'h0000;
      maskBase_r <= 5'h00;
      wordMode_r <= 1'b0;
    end else begin
      if (wrTimebase) begin
        timebase_r <= regWrData;
      end
      if (wrEventEn) begin
        eventEn_r <= regWrData;
      end
      if (wrMaskBase) begin
        maskBase_r <= regWrData[4:0];
      end
      if (wrControl) begin
        wordMode_r <= regWrData[`MDS_CTRL_WORD_BIT];
      end
    end
  end

  // Discrete form refreshes every cycle regardless of start
  always @(posedge clk) begin
    if (!rst_n) begin
      discreteOut <= 16'h0000;
    end else begin
      discreteOut <= wordMode_r ? 16'h0000 : maskedOut;
    end
  end

  // Word form; all sixteen bits change together in one cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      wordOut <= 16'h0000;
    end else begin
      wordOut <= wordMode_r ? maskedOut : 16'h0000;
    end
  end

  // Narrow registers are widened once here for the read mux
  wire [15:0] presetWord   = {11'h000, presetStep_r};
  wire [15:0] currentWord  = {11'h000, currentStep_r};
  wire [15:0] controlWord  = {15'h0000, wordMode_r};
  wire [15:0] statusWord   = {15'h0000, complete_r};
  wire [15:0] maskBaseWord = {11'h000, maskBase_r};

  // Register reads, one cycle later; unmapped reads zero
  reg [15:0] rdMux;
  always @* begin
    rdMux = 16'h0000;
    if (inRange(regAddr, `MDS_PATTERN_BASE, 7'h10)) begin
      rdMux = pattern_r[regAddr[3:0]];
    end else if (inRange(regAddr, `MDS_CPS_BASE, 7'h10)) begin
      rdMux = cps_r[regAddr[3:0]];
    end else if (inRange(regAddr, `MDS_MASK_MEM_BASE, 7'h20)) begin
      rdMux = maskMem_r[regAddr[4:0]];
    end else begin
      case (regAddr)
        `MDS_REG_COUNTS:    rdMux = countsInStep_r;
        `MDS_REG_TIMER:     rdMux = timerValue_r;
        `MDS_REG_PRESET:    rdMux = presetWord;
        `MDS_REG_CURRENT:   rdMux = currentWord;
        `MDS_REG_CONTROL:   rdMux = controlWord;
        `MDS_REG_TIMEBASE:  rdMux = timebase_r;
        `MDS_REG_STATUS:    rdMux = statusWord;
        `MDS_REG_EVENT_EN:  rdMux = eventEn_r;
        `MDS_REG_MASK_BASE: rdMux = maskBaseWord;
        default:            rdMux = 16'h0000;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= regRd ? rdMux : 16'h0000;
    end
  end

endmodule // mds_drum
`default_nettype wire

// [hdl/mds_defines.vh]
/*
  Constants for the masked event drum sequencer: register indices, field
  positions, reset values and timing figures.
  Assumes a 100 MHz clock and a register port with 16-bit data.
*/
// What this block does
// - Sixteen steps, sixteen-bit pattern, one mask each.
// - Outputs are pattern ANDed with step mask.
// - Masks read consecutively from configured base location.
// - Word variant writes masked bits as one word.
// - Each jog rising edge advances one step.
// - Step timer enabled only while start asserted.
// - Counts accumulate only while step event true.
// - Counts equal counts-per-step moves to next step.
// - Stepping stops after last step or reset.
// - Preset step loaded on run entry, reset.
// - Timebase unit is hundredths of a second.
// - Four status counters: counts, timer, preset, current.
// - Preset and current writable; others read-only.
// - Complete bit set at end, cleared by reset.
// - Masks writable anytime; new masks apply immediately.
// - Unconfigured steps and events default blank.
// - Outputs driven every scan, even start off.
// - Zero counts, true events: one step per scan.
`ifndef MDS_DEFINES_VH
`define MDS_DEFINES_VH

// Register indices
`define MDS_REG_COUNTS     7'h00
`define MDS_REG_TIMER      7'h01
`define MDS_REG_PRESET     7'h02
`define MDS_REG_CURRENT    7'h03
`define MDS_REG_CONTROL    7'h04
`define MDS_REG_TIMEBASE   7'h05
`define MDS_REG_STATUS     7'h06
`define MDS_REG_EVENT_EN   7'h07
`define MDS_REG_MASK_BASE  7'h08
`define MDS_PATTERN_BASE   7'h20
`define MDS_CPS_BASE       7'h30
`define MDS_MASK_MEM_BASE  7'h40

// Field positions
`define MDS_CTRL_WORD_BIT  0
`define MDS_STAT_DONE_BIT  0

// Sizes
`define MDS_STEPS          16
`define MDS_MASK_WORDS     32
`define MDS_LAST_STEP      5'h10
`define MDS_FIRST_STEP     5'h01

// Reset values
`define MDS_PRESET_RST     5'h01
`define MDS_TIMEBASE_RST   16'h0000
`define MDS_CONTROL_RST    16'h0000

// Timing: one timebase unit is 0.01 s
`define MDS_UNIT_NS        10000000
`define MDS_CLK_NS         10
`define MDS_UNIT_CYCLES    (`MDS_UNIT_NS / `MDS_CLK_NS)

`endif

// [dv/mds_drum_checker.sv]
/* Port checker for mds_drum, bound to the design.
   Assumes the register map of mds_defines.vh. */
`timescale 1ns/100ps
`default_nettype none
`include "mds_defines.vh"
module mds_drum_checker #(
  parameter integer UNIT_CYCLES = 10
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Pins
  input wire logic        scanPulse,
  input wire logic        runMode,
  input wire logic        startIn,
  input wire logic        resetIn,
  input wire logic        jogIn,
  input wire logic [15:0] eventIn,
  // Register port
  input wire logic [6:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  // Outputs
  input wire logic [15:0] discreteOut,
  input wire logic [15:0] wordOut,
  input wire logic        sequenceCompleteFlag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_read_idle_zero: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data outside its slot");
  a_unmapped_zero: assert property (regRd && regAddr >= 7'h60 |=> regRdData == 16'h0000)
    else $error("unmapped read not zero");
  a_status_done: assert property (regRd && regAddr == `MDS_REG_STATUS
    |=> regRdData[0] == $past(sequenceCompleteFlag)) else $error("status bit wrong");
  a_one_mode: assert property (discreteOut == 16'h0000 || wordOut == 16'h0000)
    else $error("both output forms active");
  // Pins reach the logic late, so quiet inputs are demanded over a window
  a_done_holds: assert property ((!resetIn && runMode)[*8] ##0
    (sequenceCompleteFlag && !regWr) |=> sequenceCompleteFlag) else $error("done dropped");
  a_done_steady: assert property ((sequenceCompleteFlag && !regWr)[*3]
    |-> $stable(discreteOut) && $stable(wordOut)) else $error("outputs moved when done");
  a_write_clears: assert property (regWr && (regAddr == `MDS_REG_PRESET
    || regAddr == `MDS_REG_CURRENT) |=> !sequenceCompleteFlag) else $error("done not cleared");
  a_reset_quiet: assert property ($past(rst_n) == 1'b0 |-> discreteOut == 16'h0000
    && wordOut == 16'h0000 && !sequenceCompleteFlag) else $error("outputs live after reset");
  c_done: cover property ($rose(sequenceCompleteFlag));
  c_word: cover property (wordOut != 16'h0000);
  c_status: cover property (regRd && regAddr == `MDS_REG_STATUS);
endmodule // mds_drum_checker
bind mds_drum mds_drum_checker #(.UNIT_CYCLES(UNIT_CYCLES)) chk (.clk(clk), .rst_n(rst_n),
  .scanPulse(scanPulse), .runMode(runMode), .startIn(startIn), .resetIn(resetIn),
  .jogIn(jogIn), .eventIn(eventIn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .discreteOut(discreteOut), .wordOut(wordOut),
  .sequenceCompleteFlag(sequenceCompleteFlag));
`default_nettype wire

// [dv/mds_scan_model.sv]
/* Controller scan model: a one-cycle scan pulse every PERIOD clocks.
   Assumes the clock and synchronous active-low reset of the sequencer. */
`timescale 1ns/100ps
`default_nettype none
module mds_scan_model #(
  parameter integer PERIOD = 20
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Scan marker
  output var logic  scanPulse
);
  integer cnt;
  always @(posedge clk) begin
    if (!rst_n || cnt == PERIOD - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
    scanPulse <= rst_n && (cnt == PERIOD - 1);
  end
endmodule // mds_scan_model
`default_nettype wire

// [dv/mds_drum_tb.sv]
/* Bench for mds_drum: register tasks, pin sequences, expected values.
   Assumes the scan model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`include "mds_defines.vh"
module mds_drum_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        runMode = 1'b0;
  logic        startIn = 1'b0;
  logic        resetIn = 1'b0;
  logic        jogIn = 1'b0;
  logic [15:0] eventIn = 16'h0000;
  logic [6:0]  regAddr = 7'h00;
  logic [15:0] regWrData = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  wire  [15:0] regRdData, discreteOut, wordOut;
  wire         scanPulse, doneFlag;
  integer      n_mismatch = 0, n_tests = 0, cyc = 0, n;
  logic [6:0]  k;
  always #5 clk = ~clk;
  mds_scan_model scan (.clk(clk), .rst_n(rst_n), .scanPulse(scanPulse));
  mds_drum #(.UNIT_CYCLES(10)) uut (.clk(clk), .rst_n(rst_n), .scanPulse(scanPulse),
    .runMode(runMode), .startIn(startIn), .resetIn(resetIn), .jogIn(jogIn), .eventIn(eventIn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .discreteOut(discreteOut), .wordOut(wordOut),
    .sequenceCompleteFlag(doneFlag));
  function automatic logic [15:0] pat(input logic [6:0] s);
    pat = 16'h1111 * {9'h000, s};
  endfunction
  function automatic logic [15:0] mk(input logic [6:0] j);
    mk = {j, 1'b1, ~j, 1'b0};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rc(input logic [6:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask
  // Pins pass a synchroniser, so each level is held well past its latency
  task automatic pins(input logic r, input logic j);
    @(posedge clk);
    resetIn <= r;
    jogIn <= j;
    repeat (10) @(posedge clk);
    resetIn <= 1'b0;
    jogIn <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    runMode <= 1'b1;
    repeat (10) @(posedge clk);
    rc(`MDS_REG_PRESET, 16'h0001);
    rc(`MDS_REG_CURRENT, 16'h0001);
    rc(7'h7F, 16'h0000);
    wr(`MDS_REG_COUNTS, 16'h0005);
    rc(`MDS_REG_COUNTS, 16'h0000);
    $display("test registers done");
    wr(`MDS_REG_MASK_BASE, 16'h001E);
    for (k = 0; k < 32; k++) wr(`MDS_MASK_MEM_BASE + k, mk(k));
    for (k = 1; k <= 16; k++) begin
      wr(`MDS_PATTERN_BASE + k - 7'd1, pat(k));
      wr(`MDS_REG_CURRENT, {9'h000, k});
      rc(`MDS_REG_CURRENT, {9'h000, k});
      chk(discreteOut, pat(k) & mk((k + 7'd29) & 7'h1F));
    end
    wr(`MDS_REG_CONTROL, 16'h0001);
    settle;
    chk(wordOut, pat(7'd16) & mk(7'd13));
    chk(discreteOut, 16'h0000);
    wr(`MDS_MASK_MEM_BASE + 7'd13, 16'h00FF);
    settle;
    chk(wordOut, pat(7'd16) & 16'h00FF);
    wr(`MDS_REG_CONTROL, 16'h0000);
    $display("test outputs done");
    wr(`MDS_REG_CURRENT, 16'h0001);
    do begin
      @(posedge clk);
      #1;
    end while (scanPulse !== 1'b1);
    @(posedge clk);
    startIn <= 1'b1;
    repeat (10) @(posedge clk);
    n = 0;
    while (doneFlag !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      if (doneFlag !== 1'b1 && scanPulse === 1'b1) n++;
    end
    chk(n[15:0], 16'h0010);
    rc(`MDS_REG_CURRENT, 16'h0010);
    rc(`MDS_REG_STATUS, 16'h0001);
    repeat (60) @(posedge clk);
    rc(`MDS_REG_CURRENT, 16'h0010);
    $display("test run done");
    @(posedge clk);
    startIn <= 1'b0;
    pins(1'b1, 1'b0);
    rc(`MDS_REG_CURRENT, 16'h0001);
    chk({15'h0000, doneFlag}, 16'h0000);
    wr(`MDS_REG_PRESET, 16'h0007);
    pins(1'b1, 1'b0);
    rc(`MDS_REG_CURRENT, 16'h0007);
    pins(1'b0, 1'b1);
    repeat (40) @(posedge clk);
    rc(`MDS_REG_CURRENT, 16'h0008);
    $display("test reset and jog done");
    wr(`MDS_REG_EVENT_EN, 16'h0180);
    @(posedge clk);
    startIn <= 1'b1;
    repeat (80) @(posedge clk);
    rc(`MDS_REG_CURRENT, 16'h0008);
    @(posedge clk);
    eventIn <= 16'h0080;
    repeat (80) @(posedge clk);
    rc(`MDS_REG_CURRENT, 16'h0009);
    $display("test events done");
    wr(`MDS_CPS_BASE + 7'd8, 16'h0002);
    wr(`MDS_CPS_BASE + 7'd9, 16'h270F);
    wr(`MDS_REG_TIMEBASE, 16'h0002);
    wr(`MDS_REG_EVENT_EN, 16'h0000);
    repeat (120) @(posedge clk);
    rc(`MDS_REG_CURRENT, 16'h000A);
    $display("test timed steps done");
    final_report;
  end
endmodule // mds_drum_tb
`default_nettype wire
